// [hdl/swb_pkg.sv]
// Shared types, codes and reset values of the endian byte swapper.
package swb_pkg;

    // Swap mode codes as held by the swap_mode_select_register field.
    typedef enum logic [1:0] {
        SWB_MODE_NONE = 2'h0,
        SWB_MODE_BYTE = 2'h1,
        SWB_MODE_WORD = 2'h2,
        SWB_MODE_LONG = 2'h3
    } swb_mode_t;

    // Transfer length code: number of bytes minus one.
    typedef enum logic [1:0] {
        SWB_LEN_1 = 2'h0,
        SWB_LEN_2 = 2'h1,
        SWB_LEN_3 = 2'h2,
        SWB_LEN_4 = 2'h3
    } swb_len_t;

    // Transfer direction.
    typedef enum logic {
        SWB_DIR_VME_TO_HOST = 1'b0,
        SWB_DIR_HOST_TO_VME = 1'b1
    } swb_dir_t;

    // Registered state of the swapper output stage.
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  be;
        logic        valid;
        logic        err;
    } swb_state_t;

    localparam logic [31:0] SWB_RST_DATA  = 32'h0000_0000;
    localparam logic [3:0]  SWB_RST_BE    = 4'h0;
    localparam logic        SWB_RST_VALID = 1'b0;
    localparam logic        SWB_RST_ERR   = 1'b0;
    localparam int          SWB_LATENCY   = 1;
    // Highest VME lane index, the lane carrying D31..D24.
    localparam logic [1:0]  SWB_TOP_LANE  = 2'h3;

    // Host byte address k holds the VME byte at address k xor mode.
    function automatic logic [1:0] swb_perm(input logic [1:0] k, input logic [1:0] mode);
        swb_perm = k ^ mode;
    endfunction : swb_perm

    // VME lane that carries byte address k for a transfer of length len.
    function automatic logic [1:0] swb_vlane(input logic [1:0] k, input logic [1:0] len);
        if (len == SWB_LEN_3 || len == SWB_LEN_4)
            swb_vlane = SWB_TOP_LANE - k;
        else
            swb_vlane = {1'b0, ~k[0]};
    endfunction : swb_vlane

endpackage : swb_pkg

// [hdl/swb_lane_if.sv]
// Carrier between the swapper core and one byte-lane selector.
`timescale 1ns/100ps
interface swb_lane_if;
    logic [31:0] src;
    logic [1:0]  sel;
    logic [7:0]  byte_v;

    modport mux  (input src, input sel, output byte_v);
    modport user (output src, output sel, input byte_v);
endinterface : swb_lane_if

// [hdl/swb_lane_mux.sv]
// One output byte lane: picks one of the four source lanes.
`timescale 1ns/100ps
module swb_lane_mux (
    swb_lane_if.mux lane
);
    import swb_pkg::*;

    // Plain four-way byte select; lane 0 is bits 7..0.
    always_comb
    begin
        case (lane.sel)
            2'h0:    lane.byte_v = lane.src[7:0];
            2'h1:    lane.byte_v = lane.src[15:8];
            2'h2:    lane.byte_v = lane.src[23:16];
            2'h3:    lane.byte_v = lane.src[31:24];
            default: lane.byte_v = 8'h00;
        endcase
    end
endmodule : swb_lane_mux

// [hdl/swb_top.sv]
// Byte-lane swapping datapath between a big endian VME side and a little endian host side.
`timescale 1ns/100ps

module swb_top (
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    input  wire swb_pkg::swb_dir_t  dir_i,
    input  wire swb_pkg::swb_mode_t swap_mode_select_register_i,
    input  wire swb_pkg::swb_len_t  len_i,
    input  wire logic [1:0]       addr_i,
    input  wire logic [31:0]      data_i,
    input  wire logic [3:0]       be_i,
    output logic                  out_valid_o,
    output logic [31:0]           data_o,
    output logic [3:0]            be_o,
    output logic                  err_o
);
    import swb_pkg::*;

    // How the lane maps come together.
    //
    // The datapath separates two questions that are easy to tangle.
    // The first is which VME byte address belongs to which host byte address.
    // That depends only on the swap mode and is a plain xor of the two low
    // address bits with the mode code.
    // The second is on which physical VME lane a given VME byte address travels.
    // That depends only on the transfer length and the byte address.
    // Keeping the two apart means one small function per question, and no
    // sixteen-entry table per mode that would have to be kept consistent by hand.
    //
    // Host to VME byte address, per mode (host address h):
    //   mode 0: h        character strings keep their order.
    //   mode 1: h xor 1  bytes exchanged inside each word.
    //   mode 2: h xor 2  words exchanged inside the longword.
    //   mode 3: h xor 3  full reversal of the longword.
    //
    // The VME lane of VME byte address k:
    //   three or four bytes: lane 3 - k, the longword layout.
    //   one or two bytes:    lane 1 for even k, lane 0 for odd k.
    //
    // The host lane of host byte address h is always lane h.
    // That is what makes the host side independent of the length.
    //
    // Limitation: a transfer may not cross a longword.
    // A span that does is refused with the error flag and no lane enabled,
    // because writing part of it would leave memory half updated.
    //
    // Trade-off: the whole map is combinational in front of one register.
    // That costs a little depth in the lane select path but gives a fixed
    // latency of one cycle, which keeps the far side simple.
    //
    // Hazard: a lane that is not enabled in an accepted transfer is driven to zero, not left at its
    // old value, so a consumer that ignores the enables cannot pick up a byte
    // of an earlier transfer while out_valid_o is high; idle cycles hold the old data.
    //
    // Worked example, VME to host, four bytes at address 0, VME lanes
    // holding 01 23 45 67 from lane 3 down to lane 0:
    //   mode 0 gives 67 45 23 01 from host lane 3 down to lane 0.
    //   mode 1 gives 45 67 01 23.
    //   mode 2 gives 23 01 67 45.
    //   mode 3 gives 01 23 45 67.
    //
    // The same table read the other way serves host to VME, since the xor
    // map is its own inverse and the lane rule is applied on the VME side.

    // The lane logic is written for a longword of four byte lanes.
    if (SWB_TOP_LANE != 2'h3)
    begin : g_guard
        $error("swapper lane logic needs exactly four byte lanes");
    end

    swb_state_t  state_q;
    swb_state_t  state_d;
    logic [3:0]  addr_mask;
    logic [3:0]  lane_en;
    logic [1:0]  lane_sel [4];
    logic [7:0]  lane_byte [4];
    logic        span_err;
    logic [2:0]  end_addr;

    // The addressed span addr..addr+len must stay inside one longword.
    assign end_addr = {1'b0, addr_i} + {1'b0, len_i};
    assign span_err = end_addr[2];

    // Byte-address mask of the addressed bytes, by host or VME byte address.
    always_comb
    begin
        addr_mask = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            if (!span_err && (k[2:0] >= {1'b0, addr_i}) && (k[2:0] <= end_addr))
                addr_mask[k] = 1'b1;
        end
    end

    // Per destination lane: which source lane feeds it and whether it is written.
    // Both directions share the xor permutation, which is its own inverse.
    always_comb
    begin
        logic [1:0] k;
        logic [1:0] src;
        k   = 2'h0;
        src = 2'h0;
        for (int l = 0; l < 4; l++)
        begin
            if (dir_i == SWB_DIR_VME_TO_HOST)
            begin
                // Host lane l is host byte address l, independent of length.
                k   = swb_perm(l[1:0], swap_mode_select_register_i);
                src = swb_vlane(k, len_i);
                lane_sel[l] = src;
                lane_en[l]  = be_i[src] & addr_mask[k];
            end
            else
            begin
                // VME lane l: find the VME byte address it carries for this length.
                if (len_i == SWB_LEN_3 || len_i == SWB_LEN_4)
                    k = SWB_TOP_LANE - l[1:0];
                else
                    k = {addr_i[1], ~l[0]};
                src = swb_perm(k, swap_mode_select_register_i);
                lane_sel[l] = src;
                // Upper VME lanes are idle on one and two byte transfers.
                lane_en[l]  = be_i[src] & addr_mask[k] &
                              ((len_i == SWB_LEN_3 || len_i == SWB_LEN_4) || !l[1]);
            end
        end
    end

    // Four lane selectors; mode 0 keeps addresses for strings, 1 flips within
    // words, 2 moves words, 3 reverses the longword.
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        swb_lane_if lane_bus ();
        assign lane_bus.src = data_i;
        assign lane_bus.sel = lane_sel[g];
        assign lane_byte[g] = lane_bus.byte_v;
        swb_lane_mux u_mux (
            .lane (lane_bus)
        );
    end

    // Next state: one registered stage; disabled lanes of a valid input read as zero so stale
    // bytes never leak into a valid answer; idle cycles keep the last data with no enables.
    always_comb
    begin
        state_d       = state_q;
        state_d.valid = in_valid_i;
        if (in_valid_i)
        begin
            for (int l = 0; l < 4; l++)
                state_d.data[l*8 +: 8] = lane_en[l] ? lane_byte[l] : 8'h00;
            state_d.be  = lane_en;
            state_d.err = span_err;
        end
        else
        begin
            state_d.be  = SWB_RST_BE;
            state_d.err = SWB_RST_ERR;
        end
    end

    // State register.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q.data  <= SWB_RST_DATA;
            state_q.be    <= SWB_RST_BE;
            state_q.valid <= SWB_RST_VALID;
            state_q.err   <= SWB_RST_ERR;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign out_valid_o = state_q.valid;
    assign data_o      = state_q.data;
    assign be_o        = state_q.be;
    assign err_o       = state_q.err;

endmodule : swb_top

// [verif/swb_assertions.sv]
// Port-level concurrent checks of the endian byte swapper.
`timescale 1ns/100ps
module swb_checker (
    input wire logic              mclk_i,
    input wire logic              resetn_i,
    input wire logic              in_valid_i,
    input wire swb_pkg::swb_mode_t swap_mode_select_register_i,
    input wire swb_pkg::swb_len_t  len_i,
    input wire logic [1:0]        addr_i,
    input wire logic [31:0]       data_i,
    input wire logic [3:0]        be_i,
    input wire logic              out_valid_o,
    input wire logic [31:0]       data_o,
    input wire logic [3:0]        be_o,
    input wire logic              err_o
);
    import swb_pkg::*;
    logic      full;
    swb_mode_t md;
    // Only aligned full longwords have a lane map fixed by the mode alone.
    assign full = in_valid_i && len_i == SWB_LEN_4 && addr_i == 2'h0 && be_i == 4'hf;
    assign md = swap_mode_select_register_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_answer_lat: assert property (in_valid_i |=> out_valid_o)
        else $error("answer missing");
    a_no_spur: assert property (!in_valid_i |=> !out_valid_o && be_o == 4'h0)
        else $error("answer without request");
    a_err_span: assert property (in_valid_i && ({1'b0, addr_i} + {1'b0, len_i} > 3'h3)
        |=> err_o && be_o == 4'h0) else $error("span overflow not flagged");
    a_err_quiet: assert property (in_valid_i && ({1'b0, addr_i} + {1'b0, len_i} <= 3'h3)
        |=> !err_o) else $error("false span error");
    a_long_rev: assert property (full && md == SWB_MODE_LONG |=> data_o == $past(data_i))
        else $error("longword swap wrong");
    a_no_swap: assert property (full && md == SWB_MODE_NONE
        |=> data_o == {<<8{$past(data_i)}}) else $error("no swap wrong");
    a_byte_swap: assert property (full && md == SWB_MODE_BYTE
        |=> data_o == {$past(data_i[15:0]), $past(data_i[31:16])}) else $error("byte swap wrong");
    a_word_swap: assert property (full && md == SWB_MODE_WORD |=> data_o ==
        {<<16{{<<8{$past(data_i)}}}}) else $error("word swap wrong");
    a_full_be: assert property (full |=> be_o == 4'hf)
        else $error("full enables lost");
endmodule : swb_checker
bind swb_top swb_checker u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .in_valid_i(in_valid_i),
    .swap_mode_select_register_i(swap_mode_select_register_i), .len_i(len_i), .addr_i(addr_i),
    .data_i(data_i), .be_i(be_i), .out_valid_o(out_valid_o), .data_o(data_o), .be_o(be_o),
    .err_o(err_o));

// [verif/swb_host_sink.sv]
// Host memory word fed by the swapper's answers.
`timescale 1ns/100ps
module swb_host_sink (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] data_i,
    input  wire logic [3:0]  be_i,
    output logic [31:0]      mem_o
);
    // Disabled lanes are skipped so a stray enable shows as a clobbered byte.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mem_o <= 32'hffff_ffff;
        else if (wr_i)
            for (int i = 0; i < 4; i++)
                if (be_i[i])
                    mem_o[8*i +: 8] <= data_i[8*i +: 8];
    end
endmodule : swb_host_sink

// [verif/test_vme_endian_byte_swapper.sv]
// Self-checking bench of the endian byte swapper.
`timescale 1ns/100ps
module test_vme_endian_byte_swapper;
    import swb_pkg::*;
    logic mclk_i = 1'b0, resetn_i = 1'b0, vld = 1'b0, out_valid_o, err_o;
    swb_dir_t dir = SWB_DIR_VME_TO_HOST;
    swb_mode_t mode = SWB_MODE_NONE;
    swb_len_t len = SWB_LEN_4;
    logic [1:0] addr = 2'h0;
    logic [31:0] din = 32'h0, data_o, mem;
    logic [3:0] be = 4'h0, be_o;
    int err_total = 0, n_checks = 0;
    swb_top i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .in_valid_i(vld), .dir_i(dir),
        .swap_mode_select_register_i(mode), .len_i(len), .addr_i(addr), .data_i(din),
        .be_i(be), .out_valid_o(out_valid_o), .data_o(data_o), .be_o(be_o), .err_o(err_o));
    swb_host_sink i_sink (.mclk_i(mclk_i), .resetn_i(resetn_i), .wr_i(out_valid_o),
        .data_i(data_o), .be_i(be_o), .mem_o(mem));
    // Free-running clock at 25 MHz.
    always #20 mclk_i = ~mclk_i;
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask : chk
    // Expected full longword: destination lane x takes source lane x^mode^3.
    function automatic logic [35:0] lanes(input logic [1:0] m, input logic [31:0] d,
        input logic [3:0] b);
        logic [1:0] s;
        for (int x = 0; x < 4; x++)
        begin
            s = 2'(x) ^ m ^ 2'h3;
            lanes[8*x +: 8] = b[s] ? d[8*s +: 8] : 8'h0;
            lanes[32 + x] = b[s];
        end
    endfunction : lanes
    // Inputs change on the falling edge; the answer is settled one cycle later.
    task automatic one(input swb_dir_t d, input swb_mode_t m, input swb_len_t l,
        input logic [1:0] a, input logic [31:0] v, input logic [3:0] b, input logic [36:0] e);
        @(negedge mclk_i);
        dir  = d;
        mode = m;
        len  = l;
        addr = a;
        din  = v;
        be   = b;
        vld  = 1'b1;
        @(negedge mclk_i);
        vld = 1'b0;
        chk({36'h0, out_valid_o}, 37'h1);
        chk({err_o, be_o, data_o}, e);
    endtask : one
    task automatic t_modes();
        for (int i = 0; i <= 8; i++)
        begin
            @(negedge mclk_i);
            if (i > 0)
                chk({err_o, be_o, data_o}, {1'b0, lanes(2'(i - 1), 32'h0123_4567, 4'hf)});
            dir  = swb_dir_t'(1'(i >> 2));
            mode = swb_mode_t'(2'(i));
            len  = SWB_LEN_4;
            addr = 2'h0;
            din  = 32'h0123_4567;
            be   = 4'hf;
            vld  = (i < 8);
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_mask();
        one(SWB_DIR_VME_TO_HOST, SWB_MODE_NONE, SWB_LEN_4, 2'h0, 32'ha1b2_c3d4, 4'h5,
            {1'b0, lanes(2'h0, 32'ha1b2_c3d4, 4'h5)});
        @(negedge mclk_i);
        chk(mem, 32'hd423_b267);
        $display("t_mask done");
    endtask : t_mask
    task automatic t_single();
        one(SWB_DIR_VME_TO_HOST, SWB_MODE_NONE, SWB_LEN_1, 2'h1, 32'h0000_00aa, 4'h1,
            {5'h02, 32'h0000_aa00});
        one(SWB_DIR_HOST_TO_VME, SWB_MODE_NONE, SWB_LEN_1, 2'h2, 32'h00cc_0000, 4'h4,
            {5'h02, 32'h0000_cc00});
        $display("t_single done");
    endtask : t_single
    task automatic t_err();
        one(SWB_DIR_HOST_TO_VME, SWB_MODE_NONE, SWB_LEN_2, 2'h2, 32'h1122_0000, 4'hc,
            {5'h03, 32'h0000_2211});
        one(SWB_DIR_VME_TO_HOST, SWB_MODE_NONE, SWB_LEN_2, 2'h3, 32'h0000_1122, 4'h3,
            {5'h10, 32'h0});
        $display("t_err done");
    endtask : t_err
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (16) @(negedge mclk_i);
        resetn_i = 1'b1;
        t_modes();
        t_mask();
        t_single();
        t_err();
        stop_test();
    end
endmodule : test_vme_endian_byte_swapper
